// ---- shared/ompcs_pkg.sv ----
/*
 package of the clock selection and oscillator monitor block: strap codes,
 pll settings, monitor counter sizing and carrier structs.
 assumes one 20 MHz free-running reference clock and active-low reset.
*/
package ompcs_pkg;
    localparam int REF_CLK_HZ = 20000000;
    localparam logic [2:0] STRAP_PLL_X4 = 3'h7;
    localparam logic [2:0] STRAP_PLL_X3 = 3'h6;
    localparam logic [2:0] STRAP_PLL_X8 = 3'h5;
    localparam logic [2:0] STRAP_PLL_X5 = 3'h4;
    localparam logic [2:0] STRAP_DIRECT = 3'h3;
    localparam logic [2:0] STRAP_PLL_X10 = 3'h2;
    localparam logic [2:0] STRAP_PRESCALE = 3'h1;
    localparam logic [2:0] STRAP_PLL_X16 = 3'h0;
    localparam logic [2:0] STRAP_RESET = STRAP_PLL_X4;
    localparam int MON_DISABLE_BIT = 4;
    localparam logic [4:0] MON_OVERFLOW = 5'h10;
    localparam logic [4:0] MON_CNT_RESET = 5'h00;
    localparam logic [2:0] IN_DIV_4 = 3'h4;
    localparam logic [2:0] IN_DIV_2 = 3'h2;
    localparam logic [2:0] IN_DIV_1 = 3'h1;
    localparam logic [6:0] VCO_MUL_64 = 7'h40;
    localparam logic [6:0] VCO_MUL_48 = 7'h30;
    localparam logic [6:0] VCO_MUL_40 = 7'h28;
    localparam logic [2:0] OUT_DIV_4 = 3'h4;
    localparam logic [2:0] OUT_DIV_2 = 3'h2;
    localparam logic [4:0] FACT_4 = 5'h04;
    localparam logic [4:0] FACT_3 = 5'h03;
    localparam logic [4:0] FACT_8 = 5'h08;
    localparam logic [4:0] FACT_5 = 5'h05;
    localparam logic [4:0] FACT_10 = 5'h0A;
    localparam logic [4:0] FACT_16 = 5'h10;
    localparam logic [4:0] FACT_1 = 5'h01;

    typedef enum logic [1:0] {
        OMPCS_SRC_PLL = 2'b00,
        OMPCS_SRC_DIRECT = 2'b01,
        OMPCS_SRC_PRESCALE = 2'b10,
        OMPCS_SRC_BACKUP = 2'b11
    } ompcs_src_t;

    typedef struct packed {
        logic [2:0] in_div;
        logic [6:0] vco_mul;
        logic [2:0] out_div;
        logic [4:0] factor;
    } ompcs_pll_cfg_t;

    typedef struct packed {
        ompcs_src_t src;
        logic pll_on;
        logic pll_free_run;
        logic osc_amp_on;
        logic prescale_on;
    } ompcs_clk_ctl_t;
endpackage

// ---- hw/ompcs_monitor.sv ----
/*
 oscillator failure counter: counts free-running pll cycles, cleared on
 each synchronised crystal edge, latches failure on overflow.
 assumes free_tick is a one-cycle enable from the same clock.
*/
module ompcs_monitor
    import ompcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic enable,
    input wire logic free_tick,
    input wire logic xtal_pin,
    // status
    output logic failed,
    output logic fail_pulse
);
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic failed_q;
    wire ext_edge = sync2_q ^ sync3_q;
    // a crystal edge in the same cycle clears, so it also blocks overflow
    wire overflow = enable && free_tick && !failed_q && !ext_edge
        && (cnt_q == MON_OVERFLOW - 5'h01);

    always_comb begin
        cnt_d = cnt_q;
        if (!enable || ext_edge) begin
            cnt_d = MON_CNT_RESET;
        end else if (free_tick && !failed_q) begin
            cnt_d = cnt_q + 5'h01;
        end
    end

    // crystal edges synchronised before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            cnt_q <= MON_CNT_RESET;
            failed_q <= 1'b0;
        end else begin
            sync1_q <= xtal_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            cnt_q <= cnt_d;
            if (overflow) begin
                failed_q <= 1'b1;
            end
        end
    end

    assign failed = failed_q;
    assign fail_pulse = overflow;
endmodule

// ---- hw/ompcs_top.sv ----
/*
 clock selection and oscillator failure supervision.
 assumes straps are stable around reset release, system config register
 lives elsewhere and hands its value in, reset covers all qualifying resets.
*/
module ompcs_top
    import ompcs_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // straps and configuration
    input wire logic [2:0] CLOCK_MODE_STRAPS,
    input wire logic [15:0] SYSTEM_CONFIG_REGISTER,
    // crystal input and free-running pll tick
    input wire logic CRYSTAL_INPUT_PIN,
    input wire logic PLL_FREE_TICK,
    // pll resync events
    input wire logic XTAL_EDGE_TICK,
    // outputs
    output ompcs_pkg::ompcs_clk_ctl_t CLK_CTL,
    output ompcs_pkg::ompcs_pll_cfg_t PLL_CFG,
    output logic PLL_RESYNC,
    output logic OSC_FAIL_IRQ
);
    import ompcs_pkg::*;

    logic [2:0] strap_s1_q;
    logic [2:0] strap_s2_q;
    logic [2:0] strap_q;
    logic strap_taken_q;
    logic [1:0] strap_v_q;
    logic mon_dis_s1_q;
    logic mon_dis_q;
    logic free_s1_q;
    logic free_s2_q;
    logic free_s3_q;
    logic [4:0] edge_cnt_q;
    logic resync_q;
    logic irq_q;
    ompcs_clk_ctl_t ctl_q;
    ompcs_pll_cfg_t cfg_q;
    ompcs_pll_cfg_t cfg_d;
    ompcs_clk_ctl_t ctl_d;
    logic failed;
    logic fail_pulse;

    wire is_direct = (strap_q == STRAP_DIRECT);
    wire is_prescale = (strap_q == STRAP_PRESCALE);
    wire non_pll = is_direct || is_prescale;
    wire mon_en = non_pll && !mon_dis_q;
    wire free_tick = free_s2_q && !free_s3_q;
    wire xtal_edge = XTAL_EDGE_TICK;
    wire last_edge = (edge_cnt_q >= cfg_q.factor - 5'h01);

    // pll settings per strap code
    always_comb begin
        cfg_d = '{IN_DIV_1, 7'h00, 3'h0, FACT_1};
        unique case (strap_q)
            STRAP_PLL_X4: cfg_d = '{IN_DIV_4, VCO_MUL_64, OUT_DIV_4, FACT_4};
            STRAP_PLL_X3: cfg_d = '{IN_DIV_4, VCO_MUL_48, OUT_DIV_4, FACT_3};
            STRAP_PLL_X8: cfg_d = '{IN_DIV_4, VCO_MUL_64, OUT_DIV_2, FACT_8};
            STRAP_PLL_X5: cfg_d = '{IN_DIV_4, VCO_MUL_40, OUT_DIV_2, FACT_5};
            STRAP_PLL_X10: cfg_d = '{IN_DIV_2, VCO_MUL_40, OUT_DIV_2, FACT_10};
            STRAP_PLL_X16: cfg_d = '{IN_DIV_1, VCO_MUL_64, OUT_DIV_4, FACT_16};
            STRAP_DIRECT: cfg_d = '{IN_DIV_1, 7'h00, 3'h0, FACT_1};
            STRAP_PRESCALE: cfg_d = '{IN_DIV_1, 7'h00, 3'h0, FACT_1};
        endcase
    end

    // clock source and pll control
    always_comb begin
        ctl_d.src = OMPCS_SRC_PLL;
        ctl_d.pll_on = 1'b1;
        ctl_d.pll_free_run = 1'b0;
        ctl_d.osc_amp_on = 1'b1;
        ctl_d.prescale_on = 1'b0;
        if (non_pll) begin
            ctl_d.src = is_direct ? OMPCS_SRC_DIRECT : OMPCS_SRC_PRESCALE;
            ctl_d.prescale_on = is_prescale;
            ctl_d.osc_amp_on = !is_direct;
            ctl_d.pll_on = mon_en;
            ctl_d.pll_free_run = mon_en;
            if (failed || fail_pulse) begin
                ctl_d.src = OMPCS_SRC_BACKUP;
                ctl_d.pll_on = 1'b1;
                ctl_d.pll_free_run = 1'b1;
            end
        end
    end

    // straps caught after reset release, held until next reset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_s1_q <= STRAP_RESET;
            strap_s2_q <= STRAP_RESET;
            strap_q <= STRAP_RESET;
            strap_taken_q <= 1'b0;
            strap_v_q <= 2'h0;
        end else begin
            strap_s1_q <= CLOCK_MODE_STRAPS;
            strap_s2_q <= strap_s1_q;
            // wait until the second stage holds a real pin sample
            strap_v_q <= {strap_v_q[0], 1'b1};
            if (!strap_taken_q && strap_v_q[1]) begin
                strap_q <= strap_s2_q;
                strap_taken_q <= 1'b1;
            end
        end
    end

    // config bit and free clock tick synchronisers
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mon_dis_s1_q <= 1'b0;
            mon_dis_q <= 1'b0;
            free_s1_q <= 1'b0;
            free_s2_q <= 1'b0;
            free_s3_q <= 1'b0;
        end else begin
            mon_dis_s1_q <= SYSTEM_CONFIG_REGISTER[MON_DISABLE_BIT];
            mon_dis_q <= mon_dis_s1_q;
            free_s1_q <= PLL_FREE_TICK;
            free_s2_q <= free_s1_q;
            free_s3_q <= free_s2_q;
        end
    end

    // resync strobe every f-th crystal transition in pll mode
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            edge_cnt_q <= 5'h00;
            resync_q <= 1'b0;
        end else begin
            resync_q <= 1'b0;
            if (!non_pll && strap_taken_q && xtal_edge) begin
                if (last_edge) begin
                    edge_cnt_q <= 5'h00;
                    resync_q <= 1'b1;
                end else begin
                    edge_cnt_q <= edge_cnt_q + 5'h01;
                end
            end
        end
    end

    // outputs registered; irq flag sticky until reset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_q <= '{OMPCS_SRC_PLL, 1'b1, 1'b0, 1'b1, 1'b0};
            cfg_q <= '{IN_DIV_4, VCO_MUL_64, OUT_DIV_4, FACT_4};
            irq_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            cfg_q <= cfg_d;
            if (fail_pulse) begin
                irq_q <= 1'b1;
            end
        end
    end

    ompcs_monitor u_mon (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .enable(mon_en && strap_taken_q),
        .free_tick(free_tick),
        .xtal_pin(CRYSTAL_INPUT_PIN),
        .failed(failed),
        .fail_pulse(fail_pulse)
    );

    assign CLK_CTL = ctl_q;
    assign PLL_CFG = cfg_q;
    assign PLL_RESYNC = resync_q;
    assign OSC_FAIL_IRQ = irq_q;
endmodule

// ---- testbench/ompcs_properties.sv ----
/*
 assertions on the clock selection top, bound below.
 assumes the top ports and the package constants.
*/
module ompcs_properties
    import ompcs_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // inputs
    input wire logic [2:0] CLOCK_MODE_STRAPS,
    input wire logic [15:0] SYSTEM_CONFIG_REGISTER,
    input wire logic CRYSTAL_INPUT_PIN,
    input wire logic PLL_FREE_TICK,
    input wire logic XTAL_EDGE_TICK,
    // outputs
    input ompcs_pkg::ompcs_clk_ctl_t CLK_CTL,
    input ompcs_pkg::ompcs_pll_cfg_t PLL_CFG,
    input wire logic PLL_RESYNC,
    input wire logic OSC_FAIL_IRQ
);
    logic xtal_q, free_q;
    logic [4:0] cnt_q;
    wire logic dis = SYSTEM_CONFIG_REGISTER[MON_DISABLE_BIT];
    wire logic ext = CLK_CTL.src inside {OMPCS_SRC_DIRECT, OMPCS_SRC_PRESCALE};
    wire logic step = PLL_FREE_TICK && !free_q && cnt_q != 5'h1F;
    // free ticks seen since the last crystal change
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            xtal_q <= 1'b0;
            free_q <= 1'b0;
            cnt_q <= 5'h00;
        end else begin
            xtal_q <= CRYSTAL_INPUT_PIN;
            free_q <= PLL_FREE_TICK;
            cnt_q <= CRYSTAL_INPUT_PIN != xtal_q ? 5'h00 : cnt_q + 5'(step);
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    chk_fail_count: assert property
        ($rose(OSC_FAIL_IRQ) |-> cnt_q >= 5'h10)
        else $error("failure too early");
    chk_fail_backup: assert property
        ($rose(OSC_FAIL_IRQ) |-> CLK_CTL.src == OMPCS_SRC_BACKUP)
        else $error("no backup on failure");
    chk_irq_sticky: assert property
        (OSC_FAIL_IRQ |=> OSC_FAIL_IRQ)
        else $error("irq dropped");
    chk_backup_kept: assert property
        (CLK_CTL.src == OMPCS_SRC_BACKUP |=> $stable(CLK_CTL.src))
        else $error("backup left");
    chk_pll_unwatched: assert property
        (CLK_CTL.src == OMPCS_SRC_PLL |-> !OSC_FAIL_IRQ)
        else $error("pll mode failed");
    chk_disabled_off: assert property
        (dis [*4] ##0 ext |-> !CLK_CTL.pll_on)
        else $error("pll on while disabled");
    chk_enabled_free: assert property
        ((!dis) [*4] ##0 ext |-> CLK_CTL.pll_on && CLK_CTL.pll_free_run)
        else $error("pll not free running");
    chk_resync_cause: assert property
        (PLL_RESYNC |-> $past(XTAL_EDGE_TICK)
            && CLK_CTL.src == OMPCS_SRC_PLL)
        else $error("stray resync");
    cover property ($rose(OSC_FAIL_IRQ));
    cover property (PLL_RESYNC);
    cover property (dis && ext);
endmodule

bind ompcs_top ompcs_properties ompcs_properties_inst (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .CLOCK_MODE_STRAPS(CLOCK_MODE_STRAPS),
    .SYSTEM_CONFIG_REGISTER(SYSTEM_CONFIG_REGISTER),
    .CRYSTAL_INPUT_PIN(CRYSTAL_INPUT_PIN), .PLL_FREE_TICK(PLL_FREE_TICK),
    .XTAL_EDGE_TICK(XTAL_EDGE_TICK), .CLK_CTL(CLK_CTL), .PLL_CFG(PLL_CFG),
    .PLL_RESYNC(PLL_RESYNC), .OSC_FAIL_IRQ(OSC_FAIL_IRQ));

// ---- testbench/ompcs_xtal_model.sv ----
/*
 crystal model: pin toggles while run is high, one tick per transition.
 assumes the bench clock; a stopped crystal holds its level.
*/
module ompcs_xtal_model (
    // clock and control
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] half,
    // crystal side
    output logic pin,
    output logic tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt = 4'h0;
    initial begin
        pin = 1'b0;
        tick = 1'b0;
    end
    // rate chosen by the system, kept in range
    always @(negedge clk) begin
        tick <= run && cnt == half;
        cnt <= (!run || cnt == half) ? 4'h0 : cnt + 4'h1;
        pin <= (run && cnt == half) ? ~pin : pin;
    end
endmodule

// ---- testbench/test_osc_monitor_pll_clock_select.sv ----
/*
 bench of the clock selection block: modes, pll settings, resync, failure.
 assumes the crystal model and the bound checker.
*/
module test_osc_monitor_pll_clock_select;
    import ompcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int sel; logic [17:0] v; string n;} ompcs_note_t;
    ompcs_note_t notes[$];
    ompcs_note_t nt;
    event ev;
    logic ref_clk = 1'b0, rst_n = 1'b0, free_q = 1'b0, run = 1'b0;
    logic [2:0] straps = 3'h3, s;
    logic [15:0] cfg = 16'h0000;
    logic [3:0] half = 4'h2;
    logic [1:0] fdiv = 2'h0;
    logic [6:0] e;
    logic [17:0] got;
    logic pin, tick, resync, irq;
    ompcs_clk_ctl_t ctl;
    ompcs_pll_cfg_t pllc, pc;
    int mismatches = 0, check_count = 0, tick_n, resync_n;
    ompcs_top ompcs_top_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
        .CLOCK_MODE_STRAPS(straps), .SYSTEM_CONFIG_REGISTER(cfg),
        .CRYSTAL_INPUT_PIN(pin), .PLL_FREE_TICK(free_q),
        .XTAL_EDGE_TICK(tick), .CLK_CTL(ctl), .PLL_CFG(pllc),
        .PLL_RESYNC(resync), .OSC_FAIL_IRQ(irq));
    ompcs_xtal_model ompcs_xtal_model_inst (.clk(ref_clk), .run(run),
        .half(half), .pin(pin), .tick(tick));
    always #25 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        fdiv <= (fdiv == 2'h2) ? 2'h0 : fdiv + 2'h1;
        free_q <= (fdiv == 2'h2) ? ~free_q : free_q;
    end
    always @(posedge ref_clk) begin
        tick_n += (tick === 1'b1);
        resync_n += (resync === 1'b1);
    end
    always @(ev) begin
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            case (nt.sel)
                0: got = 18'(ctl);
                1: got = pllc;
                2: got = 18'(irq);
                3: got = 18'(ctl.src);
                default: got = 18'(resync_n);
            endcase
            check_count++;
            if (got !== nt.v) begin
                mismatches++;
                $display("CHECK FAILED %s exp %h got %h", nt.n, nt.v, got);
            end
        end
    end
    function automatic ompcs_pll_cfg_t exp_cfg(logic [2:0] sc);
        case (sc)
            3'h7: return '{IN_DIV_4, VCO_MUL_64, OUT_DIV_4, FACT_4};
            3'h6: return '{IN_DIV_4, VCO_MUL_48, OUT_DIV_4, FACT_3};
            3'h5: return '{IN_DIV_4, VCO_MUL_64, OUT_DIV_2, FACT_8};
            3'h4: return '{IN_DIV_4, VCO_MUL_40, OUT_DIV_2, FACT_5};
            3'h2: return '{IN_DIV_2, VCO_MUL_40, OUT_DIV_2, FACT_10};
            default: return '{IN_DIV_1, VCO_MUL_64, OUT_DIV_4, FACT_16};
        endcase
    endfunction
    task automatic note(int sel, logic [17:0] v, string n);
        notes.push_back('{sel, v, n});
        -> ev;
    endtask
    task automatic cycles(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic boot(logic [2:0] sc, logic dis);
        rst_n = 1'b0;
        run <= 1'b0;
        straps = sc;
        half = 4'($urandom_range(6, 2));
        cfg = 16'($urandom) & 16'hFFEF | {11'h000, dis, 4'h0};
        cycles(10);
        note(0, 18'h0A, "reset ctl");
        note(2, 18'h0, "reset irq");
        rst_n = 1'b1;
        cycles(6);
        tick_n = 0;
        resync_n = 0;
        run <= 1'b1;
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h5979BE6E));
        for (int i = 0; i < 8; i++) begin
            if (i != 1 && i != 3) begin
                pc = exp_cfg(3'(i));
                boot(3'(i), 1'b0);
                note(0, 18'h0A, "pll ctl");
                note(1, pc, "pll cfg");
                for (int k = 0; k < 3000 && tick_n < 4 * pc.factor; k++) begin
                    cycles(1);
                end
                cycles(3);
                note(4, 18'h4, "resync count");
                run <= 1'b0;
                cycles(150);
                note(2, 18'h0, "pll irq");
            end
        end
        for (int i = 0; i < 2; i++) begin
            s = i ? STRAP_PRESCALE : STRAP_DIRECT;
            e = i ? 7'h2F : 7'h1C;
            boot(s, 1'b0);
            note(0, 18'(e), "watched ctl");
            cycles(300);
            note(2, 18'h0, "irq crystal on");
            run <= 1'b0;
            cycles(80);
            note(2, 18'h0, "irq early");
            cycles(40);
            note(2, 18'h1, "irq late");
            note(3, 18'(OMPCS_SRC_BACKUP), "backup src");
            run <= 1'b1;
            cfg[4] = 1'b1;
            cycles(100);
            note(3, 18'(OMPCS_SRC_BACKUP), "backup kept");
            boot(s, 1'b1);
            note(0, 18'(e & 7'h33), "disabled ctl");
            cycles(1);
            run <= 1'b0;
            cycles(200);
            note(2, 18'h0, "disabled irq");
        end
        wrap_up();
    end
    initial begin
        #1000000;
        mismatches++;
        wrap_up();
    end
endmodule
